// >>> core/acc_pkg.sv
package acc_pkg;
  // Number of calling units served
  localparam int UNIT_COUNT = 10;
  localparam int UNIT_SEL_W = 4;
  // Digit bus
  localparam int DIGIT_W = 4;
  localparam logic [3:0] END_OF_NUMBER_CODE = 4'hC;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT_REQ = 2'b01,
    ACC_PRESENT = 2'b10,
    ACC_HOLD = 2'b11
  } acc_state_type;
endpackage

// >>> core/acc_ctrl.sv
`timescale 1ns/1ns
module acc_ctrl #(
  parameter int UNITS = acc_pkg::UNIT_COUNT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Program side
  input wire logic [acc_pkg::UNIT_SEL_W-1:0] unit_sel,
  input wire logic call_start,
  input wire logic call_drop,
  input wire logic digit_load,
  input wire logic [acc_pkg::DIGIT_W-1:0] digit_in,
  input wire logic end_of_number,
  input wire logic end_mode,
  output logic digit_accept,
  output logic unit_ready,
  output logic digit_wanted,
  output logic abandon_flag,
  output logic modem_ready,
  output logic call_busy,
  // Calling unit side
  input wire logic [UNITS-1:0] unit_powered,
  input wire logic [UNITS-1:0] line_occupied,
  input wire logic [UNITS-1:0] abandon_retry,
  input wire logic [UNITS-1:0] modem_on_line,
  input wire logic [UNITS-1:0] next_digit_request,
  output logic [UNITS-1:0] digit_valid,
  output logic [UNITS-1:0] go_off_hook_request,
  output logic [UNITS-1:0] digit_bit0,
  output logic [UNITS-1:0] digit_bit1,
  output logic [UNITS-1:0] digit_bit2,
  output logic [UNITS-1:0] digit_bit3
);

  // ************************************************
  // Call state
  // ************************************************
  acc_pkg::acc_state_type state_q, state_d;
  logic [acc_pkg::UNIT_SEL_W-1:0] unit_q, unit_d;
  logic [acc_pkg::DIGIT_W-1:0] digit_q, digit_d;
  logic valid_q, valid_d;
  logic hook_q, hook_d;
  logic sel_ok;
  logic cur_ready;
  logic cur_req;

  function automatic logic pick(input logic [UNITS-1:0] v, input logic [acc_pkg::UNIT_SEL_W-1:0] i);
    pick = v[i];
  endfunction

  assign sel_ok = (unit_sel < acc_pkg::UNIT_SEL_W'(UNITS));
  assign cur_ready = sel_ok && pick(unit_powered, unit_sel) && !pick(line_occupied, unit_sel);
  assign cur_req = pick(next_digit_request, unit_q);
  assign digit_accept = (state_q == acc_pkg::ACC_WAIT_REQ) && cur_req && !call_drop;

  always_comb begin
    state_d = state_q;
    unit_d = unit_q;
    digit_d = digit_q;
    valid_d = valid_q;
    hook_d = hook_q;
    unique case (state_q)
      acc_pkg::ACC_IDLE: begin
        if (call_start && cur_ready) begin
          unit_d = unit_sel;
          hook_d = 1'b1;
          state_d = acc_pkg::ACC_WAIT_REQ;
        end
      end
      acc_pkg::ACC_WAIT_REQ: begin
        if (digit_load && cur_req) begin
          // Digit placed one cycle before valid rises so it is settled
          // In answer mode the unit listens for the answer, so no end code goes out
          digit_d = (end_of_number && end_mode) ? acc_pkg::END_OF_NUMBER_CODE : digit_in;
          state_d = acc_pkg::ACC_PRESENT;
        end
      end
      acc_pkg::ACC_PRESENT: begin
        valid_d = 1'b1;
        state_d = acc_pkg::ACC_HOLD;
      end
      acc_pkg::ACC_HOLD: begin
        if (!cur_req) begin
          valid_d = 1'b0;
          state_d = acc_pkg::ACC_WAIT_REQ;
        end
      end
    endcase
    // Hanging up is only ever the program's choice, never the unit's
    if (call_drop) begin
      hook_d = 1'b0;
      valid_d = 1'b0;
      state_d = acc_pkg::ACC_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= acc_pkg::ACC_IDLE;
      unit_q <= '0;
      digit_q <= acc_pkg::DIGIT_RST;
      valid_q <= 1'b0;
      hook_q <= 1'b0;
    end else begin
      state_q <= state_d;
      unit_q <= unit_d;
      digit_q <= digit_d;
      valid_q <= valid_d;
      hook_q <= hook_d;
    end
  end

  // ************************************************
  // Lead fan-out
  // ************************************************
  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      digit_valid[i] = valid_q && (unit_q == acc_pkg::UNIT_SEL_W'(i));
      go_off_hook_request[i] = hook_q && (unit_q == acc_pkg::UNIT_SEL_W'(i));
      digit_bit0[i] = digit_q[0];
      digit_bit1[i] = digit_q[1];
      digit_bit2[i] = digit_q[2];
      digit_bit3[i] = digit_q[3];
    end
  end

  // ************************************************
  // Program status
  // ************************************************
  assign call_busy = hook_q;
  assign unit_ready = cur_ready;
  assign digit_wanted = hook_q && cur_req && (state_q == acc_pkg::ACC_WAIT_REQ);
  assign abandon_flag = hook_q && pick(abandon_retry, unit_q);
  assign modem_ready = hook_q && pick(modem_on_line, unit_q);

  // ************************************************
  // Checks: call setup and drop
  // ************************************************
  start_ready_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == acc_pkg::ACC_IDLE && call_start && cur_ready && !call_drop) |=> hook_q)
    else $error("call request not raised");

  start_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == acc_pkg::ACC_IDLE && call_start && !cur_ready && !call_drop) |=> !hook_q)
    else $error("call request raised without ready");

  ready_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hook_q) |-> $past(cur_ready))
    else $error("call request without ready");

  ready_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    unit_ready |-> (pick(unit_powered, unit_sel) && !pick(line_occupied, unit_sel)))
    else $error("ready without power or with line busy");

  hook_unit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0(go_off_hook_request))
    else $error("call request on more than one unit");

  hook_match_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    hook_q |-> (go_off_hook_request != '0))
    else $error("call request lead not driven");

  hook_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (hook_q && !call_drop) |=> hook_q)
    else $error("call dropped without program");

  hook_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(hook_q) |-> ($past(call_drop) || $past(sys_rst)))
    else $error("call request fell without drop");

  drop_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    call_drop |=> (state_q == acc_pkg::ACC_IDLE && !hook_q && !valid_q))
    else $error("drop did not clear the call");

  call_active_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q != acc_pkg::ACC_IDLE) |-> hook_q)
    else $error("digit exchange outside a call");

  // ************************************************
  // Checks: digit handshake
  // ************************************************
  valid_after_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_load && digit_accept) |=> ##1 valid_q)
    else $error("valid not raised two cycles after load");

  valid_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(valid_q) |-> $stable(digit_q))
    else $error("digit changed as valid rose");

  load_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_load && !digit_accept && state_q == acc_pkg::ACC_WAIT_REQ && !call_drop) |=>
    (state_q == acc_pkg::ACC_WAIT_REQ && $stable(digit_q)))
    else $error("digit taken without request");

  digit_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_load && digit_accept && !(end_of_number && end_mode)) |=> (digit_q == $past(digit_in)))
    else $error("loaded digit not presented");

  eon_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_load && digit_accept && end_of_number && end_mode) |=> (digit_q == acc_pkg::END_OF_NUMBER_CODE))
    else $error("end code not presented");

  valid_state_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    valid_q |-> (state_q == acc_pkg::ACC_HOLD))
    else $error("valid outside the hold state");

  valid_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (valid_q && cur_req && !call_drop) |=> valid_q)
    else $error("valid fell while request stood");

  valid_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == acc_pkg::ACC_HOLD && !cur_req && !call_drop) |=> !valid_q)
    else $error("valid did not fall after request dropped");

  hold_return_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == acc_pkg::ACC_HOLD && !cur_req && !call_drop) |=> (state_q == acc_pkg::ACC_WAIT_REQ))
    else $error("no return to wait for next digit");

  digit_stable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (valid_q && $past(valid_q)) |-> $stable(digit_q))
    else $error("digit changed while valid");

  leads_after_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!valid_q && $past(valid_q) && !$past(sys_rst)) |-> $stable(digit_q))
    else $error("digit changed as valid fell");

  // ************************************************
  // Checks: lead fan-out
  // ************************************************
  valid_onehot_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0(digit_valid))
    else $error("valid on more than one unit");

  valid_unit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((digit_valid & ~go_off_hook_request) == '0))
    else $error("valid on a unit not called");

  lead_weight_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ({digit_bit3[0], digit_bit2[0], digit_bit1[0], digit_bit0[0]} == digit_q))
    else $error("digit leads misweighted");

  lead_bit0_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_bit0 == {UNITS{digit_q[0]}}))
    else $error("digit lead of weight 1 wrong");

  lead_bit1_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_bit1 == {UNITS{digit_q[1]}}))
    else $error("digit lead of weight 2 wrong");

  lead_bit2_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_bit2 == {UNITS{digit_q[2]}}))
    else $error("digit lead of weight 4 wrong");

  lead_bit3_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_bit3 == {UNITS{digit_q[3]}}))
    else $error("digit lead of weight 8 wrong");

  // ************************************************
  // Checks: program status
  // ************************************************
  abandon_seen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (hook_q && |(abandon_retry & go_off_hook_request)) |-> abandon_flag)
    else $error("abandon not reported");

  wanted_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (digit_wanted && !call_drop) |-> digit_accept)
    else $error("digit wanted but not accepted");

  busy_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    call_busy == (go_off_hook_request != '0))
    else $error("busy status disagrees with call request");

  modem_seen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (hook_q && |(modem_on_line & go_off_hook_request)) |-> modem_ready)
    else $error("modem status not reported");

  status_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !hook_q |-> (!modem_ready && !abandon_flag && !digit_wanted))
    else $error("status shown without a call");
endmodule

// >>> verif/acc_unit_model.sv
`timescale 1ns/1ns
// ******
// Calling unit model
// ******
module acc_unit_model #(
  parameter int UNITS = 10
) (
  // Bench controls
  input wire logic core_clk,
  input wire logic [UNITS-1:0] tone,
  // Controller leads
  input wire logic [UNITS-1:0] hook,
  input wire logic [UNITS-1:0] dval,
  input wire logic [3:0] dig,
  // Unit leads
  output logic [UNITS-1:0] modem,
  output logic [UNITS-1:0] req,
  output logic [3:0] seen
);
  int cnt [UNITS];
  // Dial time grows with index, so units answer both promptly and slowly
  always @(posedge core_clk) begin
    for (int i = 0; i < UNITS; i++) begin
      if (!hook[i]) begin
        req[i] <= 1'b0;
        modem[i] <= 1'b0;
        cnt[i] <= i;
      end else if (req[i] && dval[i]) begin
        seen <= dig;
        req[i] <= 1'b0;
        cnt[i] <= i + 2;
        if (dig == 4'hC || tone[i]) begin
          modem[i] <= 1'b1;
        end
      end else if (!req[i] && !dval[i]) begin
        if (cnt[i] == 0) begin
          req[i] <= 1'b1;
        end else begin
          cnt[i] <= cnt[i] - 1;
        end
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ns
// ******
// Controller bench
// ******
module tb_top;
  logic core_clk, sys_rst, start, drop, load, end_of_number_code, mode, acc, rdy, want, abf, mrdy, busy;
  logic [3:0] sel, din, seen;
  logic [9:0] pwr, tone, tmo, modem, req, dval, hook, b0, b1, b2, b3;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Each row: digit in, end flag, leads expected
  logic [11:0] rows [6] = '{12'h101, 12'h202, 12'h404, 12'h808, 12'h909, 12'h000};
  acc_ctrl u_acc_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .unit_sel(sel), .call_start(start),
    .call_drop(drop), .digit_load(load), .digit_in(din), .end_of_number(end_of_number_code), .end_mode(mode),
    .digit_accept(acc), .unit_ready(rdy), .digit_wanted(want), .abandon_flag(abf), .modem_ready(mrdy),
    .call_busy(busy), .unit_powered(pwr), .line_occupied(hook), .abandon_retry(tmo),
    .modem_on_line(modem), .next_digit_request(req), .digit_valid(dval), .go_off_hook_request(hook),
    .digit_bit0(b0), .digit_bit1(b1), .digit_bit2(b2), .digit_bit3(b3));
  acc_unit_model u_acc_unit_model (.core_clk(core_clk), .tone(tone), .hook(hook), .dval(dval),
    .dig({b3[0], b2[0], b1[0], b0[0]}), .modem(modem), .req(req), .seen(seen));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // A hang ends the run instead of stalling it
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic send(input logic [3:0] d, input logic e, input logic [3:0] x);
    int k;
    for (k = 0; k < 40 && acc !== 1'b1; k++) tick(1);
    chk("want", want, 10'h1);
    din = d;
    end_of_number_code = e;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    for (k = 0; k < 9 && dval[sel] !== 1'b1; k++) tick(1);
    chk("dval", dval, 10'h1 << sel);
    chk("leads", {b3[sel], b2[sel], b1[sel], b0[sel]}, x);
    for (k = 0; k < 9 && req[sel] === 1'b1; k++) tick(1);
    chk("leads", {b3[sel], b2[sel], b1[sel], b0[sel]}, x);
    tick(2);
    chk("dval", dval, 10'h0);
    chk("seen", seen, x);
  endtask
  task automatic call(input logic [3:0] u, input logic r);
    sel = u;
    tick(1);
    chk("ready", rdy, r);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(1);
    chk("hook", hook, r ? 10'h1 << u : 10'h0);
    chk("busy", busy, r);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {sys_rst, start, drop, load, end_of_number_code, mode, sel, din, tone, tmo} = '0;
    sys_rst = 1'b1;
    mode = 1'b1;
    pwr = 10'h3F7;
    tick(12);
    sys_rst = 1'b0;
    chk("reset", {hook, dval}, 20'h0);
    call(4'h3, 1'b0);
    call(4'h9, 1'b1);
    foreach (rows[i]) send(rows[i][11:8], rows[i][4], rows[i][3:0]);
    send(4'h5, 1'b1, 4'hC);
    din = 4'hF;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    chk("refused", {b3[9], b2[9], b1[9], b0[9]}, 10'hC);
    chk("modem", mrdy, 10'h1);
    tmo[9] = 1'b1;
    tick(1);
    chk("abandon", abf, 10'h1);
    chk("hook", hook, 10'h200);
    drop = 1'b1;
    tick(1);
    drop = 1'b0;
    tick(1);
    chk("hook", hook, 10'h0);
    tone[0] = 1'b1;
    mode = 1'b0;
    call(4'h0, 1'b1);
    send(4'h7, 1'b1, 4'h7);
    chk("modem", mrdy, 10'h1);
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    chk("reset", {hook, dval}, 20'h0);
    stop_test();
  end
endmodule
